// ===== core/cpu_move_return_config_ops.sv
// Purpose: executes move-to-file, no-op, interrupt return, config load
// Assumes: program memory answers the fetch address in the same cycle
// Notes: stack, ALU and full file map belong to neighbouring units
// What this block does
// - a move copies the accumulator to its file in one cycle, flags kept.
// - an interrupt return pops the stack into the pc, flags untouched.
// - an interrupt return sets the global enable, bit 7 of irq control.
// - an interrupt return lasts two cycles while being a single word.
// - the legacy load copies the accumulator to the config reg in one cycle.
// - the config register is also read and written by its file address.
`timescale 1ns/1ps
`default_nettype none
module cpu_move_return_config_ops
   import cpu_ops_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [13:0] insn_i,
   input wire logic [7:0] acc_i,
   input wire logic [12:0] stack_top_i,
   input wire logic [6:0] file_rd_addr_i,
   input wire logic file_wr_en_i,
   input wire logic [6:0] file_wr_addr_i,
   input wire logic [7:0] file_wr_data_i,
   output logic [12:0] pc_o,
   output logic stack_pop_o,
   output var file_wr_t file_wr_o,
   output logic [7:0] cfg_reg_o,
   output logic [7:0] irq_control_reg_o,
   output logic global_irq_enable_o,
   output logic [7:0] file_rd_data_o,
   output logic unknown_op_o
);
   // ==========================================================
   // decode and sequencing
   typedef enum logic [1:0] {
      ST_EXEC = 2'b01,
      ST_FLUSH = 2'b10
   } state_t;

   state_t state_q;
   logic move_op, no_operation_op, return_from_interrupt_op, cfg_op;
   logic [12:0] pc_q;
   logic [7:0] cfg_q, irq_q;
   logic pop_q;
   file_wr_t wr_q;
   logic [7:0] rd_q;
   logic unk_q;
   logic exec;

   op_decode u_dec (
      .insn_i(insn_i),
      .is_move_o(move_op),
      .is_idle_o(no_operation_op),
      .is_ret_o(return_from_interrupt_op),
      .is_cfg_o(cfg_op)
   );

   // the fetched word during the flush cycle is discarded
   assign exec = state_q == ST_EXEC;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_EXEC;
      end else begin
         case (state_q)
            ST_EXEC: begin
               if (return_from_interrupt_op) begin
                  state_q <= ST_FLUSH;
               end
            end
            ST_FLUSH: state_q <= ST_EXEC;
            default: state_q <= ST_EXEC;
         endcase
      end
   end

   // ==========================================================
   // program counter
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pc_q <= PC_RESET;
         pop_q <= 1'b0;
      end else begin
         pop_q <= exec && return_from_interrupt_op;
         if (exec && return_from_interrupt_op) begin
            pc_q <= stack_top_i;
         end else begin
            pc_q <= pc_q + 13'h0001;
         end
      end
   end

   // ==========================================================
   // file writes from the move opcode, flags never touched here
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_q <= '0;
      end else begin
         wr_q.en <= exec && move_op;
         wr_q.addr <= insn_i[6:0];
         wr_q.data <= acc_i;
      end
   end

   // ==========================================================
   // config register: legacy load beats an external write
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_q <= CFG_RESET;
      end else if (exec && cfg_op) begin
         cfg_q <= acc_i;
      end else if (exec && move_op && insn_i[6:0] == FADDR_CFG) begin
         cfg_q <= acc_i;
      end else if (file_wr_en_i && file_wr_addr_i == FADDR_CFG) begin
         cfg_q <= file_wr_data_i;
      end
   end

   // ==========================================================
   // interrupt control: return sets the enable, set wins over writes
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_q <= IRQ_CTRL_RESET;
      end else begin
         if (exec && move_op && insn_i[6:0] == FADDR_IRQ_CTRL) begin
            irq_q <= acc_i;
         end else if (file_wr_en_i && file_wr_addr_i == FADDR_IRQ_CTRL) begin
            irq_q <= file_wr_data_i;
         end
         if (exec && return_from_interrupt_op) begin
            irq_q[IRQ_ENABLE_BIT] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // direct read port and illegal-op flag
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_q <= 8'h00;
         unk_q <= 1'b0;
      end else begin
         if (file_rd_addr_i == FADDR_CFG) begin
            rd_q <= cfg_q;
         end else if (file_rd_addr_i == FADDR_IRQ_CTRL) begin
            rd_q <= irq_q;
         end else begin
            rd_q <= 8'h00;
         end
         unk_q <= exec && !(move_op || no_operation_op ||
                  return_from_interrupt_op || cfg_op);
      end
   end

   assign pc_o = pc_q;
   assign stack_pop_o = pop_q;
   assign file_wr_o = wr_q;
   assign cfg_reg_o = cfg_q;
   assign irq_control_reg_o = irq_q;
   assign global_irq_enable_o = irq_q[IRQ_ENABLE_BIT];
   assign file_rd_data_o = rd_q;
   assign unknown_op_o = unk_q;

   // ==========================================================
   // checks
   property p_move_write;
      @(posedge clk_i) disable iff (!arst_n_i)
      exec && move_op |=> file_wr_o.en && file_wr_o.data == $past(acc_i)
         && file_wr_o.addr == $past(insn_i[6:0]);
   endproperty
   a_move_write: assert property (p_move_write)
      else $error("move did not write accumulator");

   property p_ret_pc;
      @(posedge clk_i) disable iff (!arst_n_i)
      exec && return_from_interrupt_op |=>
         pc_o == $past(stack_top_i) && stack_pop_o;
   endproperty
   a_ret_pc: assert property (p_ret_pc)
      else $error("return did not load stack top");

   property p_ret_irq_en;
      @(posedge clk_i) disable iff (!arst_n_i)
      exec && return_from_interrupt_op |=> global_irq_enable_o;
   endproperty
   a_ret_irq_en: assert property (p_ret_irq_en)
      else $error("return did not set interrupt enable");

   property p_ret_two;
      @(posedge clk_i) disable iff (!arst_n_i)
      exec && return_from_interrupt_op |=> !exec ##1 exec;
   endproperty
   a_ret_two: assert property (p_ret_two)
      else $error("return not two cycles");

   property p_cfg_load;
      @(posedge clk_i) disable iff (!arst_n_i)
      exec && cfg_op |=> cfg_reg_o == $past(acc_i) && !file_wr_o.en;
   endproperty
   a_cfg_load: assert property (p_cfg_load)
      else $error("config load failed");

   property p_cfg_direct;
      @(posedge clk_i) disable iff (!arst_n_i)
      file_wr_en_i && file_wr_addr_i == FADDR_CFG && !(exec && (cfg_op ||
         move_op)) |=> cfg_reg_o == $past(file_wr_data_i);
   endproperty
   a_cfg_direct: assert property (p_cfg_direct)
      else $error("direct config write lost");

   property p_idle;
      @(posedge clk_i) disable iff (!arst_n_i)
      exec && no_operation_op && !file_wr_en_i |=>
         pc_o == $past(pc_o) + 13'h0001
         && !file_wr_o.en && !stack_pop_o && $stable(cfg_reg_o)
         && $stable(irq_control_reg_o);
   endproperty
   a_idle: assert property (p_idle)
      else $error("no-op changed state");

   property p_pop_single;
      @(posedge clk_i) disable iff (!arst_n_i)
      stack_pop_o |=> !stack_pop_o;
   endproperty
   a_pop_single: assert property (p_pop_single)
      else $error("double stack pop");
endmodule
`default_nettype wire

// ===== core/cpu_ops_pkg.sv
// Purpose: shared constants and types for the move/return/config decoder
// Assumes: 14-bit instruction words, 8-bit data path, 7-bit file address
// Notes: return and config load are full-word patterns; move masks its address, no-op its middle bits
package cpu_ops_pkg;
   localparam int INSN_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 13;
   // ==========================================================
   // opcode patterns
   localparam logic [13:0] OP_MOVE_ACC_MASK = 14'h3F80;
   localparam logic [13:0] OP_MOVE_ACC_VAL = 14'h0080;
   localparam logic [13:0] OP_IDLE_MASK = 14'h3F9F;
   localparam logic [13:0] OP_IDLE_VAL = 14'h0000;
   localparam logic [13:0] OP_RETURN_IRQ = 14'h0009;
   localparam logic [13:0] OP_CFG_LOAD = 14'h0062;
   // ==========================================================
   // file map and fields
   localparam logic [6:0] FADDR_CFG = 7'h01;
   localparam logic [6:0] FADDR_IRQ_CTRL = 7'h0B;
   localparam int IRQ_ENABLE_BIT = 7;
   localparam logic [7:0] CFG_RESET = 8'hFF;
   localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [1:0] RETURN_CYCLES = 2'h2;

   typedef struct packed {
      logic en;
      logic [6:0] addr;
      logic [7:0] data;
   } file_wr_t;
endpackage

// ===== core/op_decode.sv
// Purpose: classify one instruction word
// Assumes: word is stable during the decode cycle
// Notes: purely combinational, one class at a time
`timescale 1ns/1ps
`default_nettype none
module op_decode
   import cpu_ops_pkg::*;
(
   input wire logic [13:0] insn_i,
   output logic is_move_o,
   output logic is_idle_o,
   output logic is_ret_o,
   output logic is_cfg_o
);
   assign is_move_o = (insn_i & OP_MOVE_ACC_MASK) == OP_MOVE_ACC_VAL;
   assign is_idle_o = (insn_i & OP_IDLE_MASK) == OP_IDLE_VAL;
   assign is_ret_o = insn_i == OP_RETURN_IRQ;
   assign is_cfg_o = insn_i == OP_CFG_LOAD;
endmodule
`default_nettype wire

// ===== tb/prog_mem_model.sv
// Purpose: program memory seen by the decoder, answering the fetch address
// Assumes: the bench fills the words before reset is released
// Notes: combinational read, the same cycle as the address
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   input wire logic [12:0] pc_i,
   output logic [13:0] insn_o
);
   logic [13:0] mem [0:63];
   // ==========================================================
   // fetch
   // the program repeats every 64 words, so any jump target stays inside it
   assign insn_o = mem[pc_i[5:0]];
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: random program run against a reference model of the decoder
// Assumes: one clock, asynchronous active-low reset
// Notes: read data is checked against the value held before each edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cpu_ops_pkg::*;
   logic clk_i = 1'b0, arst_n_i = 1'b0, file_wr_en_i = 1'b0;
   logic [7:0] acc_i = 8'h00, file_wr_data_i = 8'h00;
   logic [12:0] stack_top_i = 13'h0000, pc_o, e_pc = 13'h0000;
   logic [6:0] file_rd_addr_i = 7'h00, file_wr_addr_i = 7'h00, e_addr;
   logic [13:0] insn;
   logic stack_pop_o, global_irq_enable_o, unknown_op_o;
   logic e_pop, e_wen, e_unk, flush = 1'b0, was_flush;
   logic [7:0] cfg_reg_o, irq_control_reg_o, file_rd_data_o, e_data;
   logic [7:0] e_cfg = CFG_RESET, e_irq = IRQ_CTRL_RESET, o_rd;
   file_wr_t file_wr_o;
   logic [31:0] seed = 32'h50;
   int error_cnt = 0, comparisons = 0, i, a;
   cpu_move_return_config_ops i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .insn_i(insn), .acc_i(acc_i), .stack_top_i(stack_top_i),
      .file_rd_addr_i(file_rd_addr_i), .file_wr_en_i(file_wr_en_i),
      .file_wr_addr_i(file_wr_addr_i), .file_wr_data_i(file_wr_data_i),
      .pc_o(pc_o), .stack_pop_o(stack_pop_o), .file_wr_o(file_wr_o),
      .cfg_reg_o(cfg_reg_o), .irq_control_reg_o(irq_control_reg_o),
      .global_irq_enable_o(global_irq_enable_o),
      .file_rd_data_o(file_rd_data_o), .unknown_op_o(unknown_op_o));
   prog_mem_model i_mem (.pc_i(pc_o), .insn_o(insn));
   // ==========================================================
   // helpers
   initial forever #2.5 clk_i = ~clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [6:0] pick(logic [31:0] r);
      return (r[1:0] == 2'h0) ? r[8:2] : (r[0] ? FADDR_CFG : FADDR_IRQ_CTRL);
   endfunction
   function automatic logic [7:0] rd_of(logic [6:0] ad);
      return (ad == FADDR_CFG) ? e_cfg :
         (ad == FADDR_IRQ_CTRL) ? e_irq : 8'h00;
   endfunction
   task automatic chk(string n, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (exp !== got) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, exp, got);
      end
   endtask
   task automatic drive();
      acc_i <= 8'(rnd());
      stack_top_i <= 13'(rnd() % 64);
      file_rd_addr_i <= pick(rnd());
      file_wr_en_i <= (rnd() % 4 == 0);
      file_wr_addr_i <= pick(rnd());
      file_wr_data_i <= 8'(rnd());
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // reference model: one call per clock cycle, flush cycles included, inputs settled
   task automatic predict();
      o_rd = rd_of(file_rd_addr_i);
      was_flush = flush;
      {e_pop, e_wen, e_unk, flush} = 4'h0;
      e_pc = e_pc + 13'h0001;
      if (was_flush) begin
      end else if ((insn & OP_MOVE_ACC_MASK) == OP_MOVE_ACC_VAL) begin
         {e_wen, e_addr, e_data} = {1'b1, insn[6:0], acc_i};
      end else if (insn == OP_RETURN_IRQ) begin
         {e_pc, e_pop, flush} = {stack_top_i, 2'b11};
      end else if ((insn & OP_IDLE_MASK) != OP_IDLE_VAL && insn != OP_CFG_LOAD)
         e_unk = 1'b1;
      if (file_wr_en_i && file_wr_addr_i == FADDR_CFG) e_cfg = file_wr_data_i;
      if (file_wr_en_i && file_wr_addr_i == FADDR_IRQ_CTRL)
         e_irq = file_wr_data_i;
      if (e_wen && e_addr == FADDR_CFG) e_cfg = acc_i;
      if (e_wen && e_addr == FADDR_IRQ_CTRL) e_irq = acc_i;
      if (!was_flush && insn == OP_CFG_LOAD) e_cfg = acc_i;
      if (e_pop) e_irq[IRQ_ENABLE_BIT] = 1'b1;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      for (i = 0; i < 64; i++) begin
         a = rnd();
         case (a % 6)
            0, 5: i_mem.mem[i] = OP_MOVE_ACC_VAL | 14'(pick(rnd()));
            1: i_mem.mem[i] = 14'(a & 32'h60);
            2: i_mem.mem[i] = OP_RETURN_IRQ;
            3: i_mem.mem[i] = OP_CFG_LOAD;
            default: i_mem.mem[i] = 14'h2000 | 14'(a[12:5]);
         endcase
      end
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      drive();
      for (i = 0; i < 800; i++) begin
         @(negedge clk_i);
         predict();
         @(posedge clk_i);
         drive();
         #1;
         chk("pc", e_pc, pc_o);
         chk("pop", e_pop, stack_pop_o);
         chk("wr_en", e_wen, file_wr_o.en);
         if (e_wen) chk("wr", {e_addr, e_data}, file_wr_o[14:0]);
         chk("cfg", e_cfg, cfg_reg_o);
         chk("irq", e_irq, irq_control_reg_o);
         chk("irq_enable", e_irq[IRQ_ENABLE_BIT], global_irq_enable_o);
         chk("rd", o_rd, file_rd_data_o);
         chk("unknown", e_unk, unknown_op_o);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
